// ---- src/spfs_pkg.sv ----
// Constants, field layout and carrier types of the serial port block
// ****************************************************************
// ****************************************************************
package spfs_pkg;

	// Register offsets (byte addresses)
	localparam logic [7:0] SPFS_OFF_CTRL  = 8'h00;
	localparam logic [7:0] SPFS_OFF_DATA  = 8'h08;
	localparam logic [7:0] SPFS_OFF_FLAGS = 8'h0C;
	localparam logic [7:0] SPFS_OFF_PRESC = 8'h10;
	localparam logic [7:0] SPFS_OFF_MASK  = 8'h14;
	localparam logic [7:0] SPFS_OFF_RAW   = 8'h18;
	localparam logic [7:0] SPFS_OFF_MIS   = 8'h1C;
	localparam logic [7:0] SPFS_OFF_CLR   = 8'h20;

	// Control word zero fields
	localparam int SPFS_CTL_SIZE_LSB  = 0;
	localparam int SPFS_CTL_SLAVE_BIT = 5;
	localparam int SPFS_CTL_SCR_LSB   = 8;
	localparam int SPFS_CTL_RXSEL_LSB = 16;
	localparam int SPFS_CTL_TXSEL_LSB = 19;
	localparam logic [31:0] SPFS_CTRL_RST  = 32'h0000_0007;
	localparam logic [31:0] SPFS_CTRL_WMSK = 32'h003F_FF3F;

	// Event bit positions in raw, mask and masked registers
	localparam int SPFS_EV_OVR = 0;
	localparam int SPFS_EV_TMO = 1;
	localparam int SPFS_EV_RXL = 2;
	localparam int SPFS_EV_TXL = 3;
	localparam int SPFS_EV_UND = 4;
	localparam int SPFS_EV_TXE = 5;
	localparam int SPFS_NUM_EV = 6;

	// Status flag positions
	localparam int SPFS_FL_TXE  = 0;
	localparam int SPFS_FL_TXR  = 1;
	localparam int SPFS_FL_RXD  = 2;
	localparam int SPFS_FL_RXF  = 3;
	localparam int SPFS_FL_BUSY = 4;

	localparam logic [7:0] SPFS_PRESC_RST = 8'h00;
	localparam logic [5:0] SPFS_MASK_RST  = 6'h00;

	// Level select codes
	localparam logic [2:0] SPFS_LVL_1 = 3'h0;
	localparam logic [2:0] SPFS_LVL_4 = 3'h1;
	localparam logic [2:0] SPFS_LVL_8 = 3'h2;

	// Receive timeout in bit periods
	localparam logic [5:0] SPFS_TMO_BITS = 6'h20;

	// FIFO depth as address width
	localparam int SPFS_FIFO_AW = 3;

	typedef enum logic [1:0] {
		SPFS_IDLE  = 2'b00,
		SPFS_LOAD  = 2'b01,
		SPFS_SHIFT = 2'b11,
		SPFS_DONE  = 2'b10
	} spfs_state_t;

	typedef struct packed {
		logic sclk;
		logic mosi;
		logic miso;
		logic cs_n;
	} spfs_line_in_t;

	typedef struct packed {
		logic sclk;
		logic sclk_oe;
		logic mosi;
		logic mosi_oe;
		logic miso;
		logic miso_oe;
		logic cs_n;
		logic cs_n_oe;
	} spfs_line_out_t;

endpackage : spfs_pkg

// ---- src/spfs_mem.sv ----
// Small word memory with registered read data for the FIFOs
`timescale 1ns/1ps
module spfs_mem #(
	parameter int DW = 32,
	parameter int AW = 3
) (
	// Clock
	input  wire logic          mclk,
	// Write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	// Read port
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);
	logic [DW-1:0] mem_q [0:(1<<AW)-1];

	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rd_en) begin
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule : spfs_mem

// ---- src/spfs_top.sv ----
// Serial port register side, FIFOs, shifter, prescaler and events
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
module spfs_top #(
	parameter int AW = spfs_pkg::SPFS_FIFO_AW
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	// Wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	// Serial line
	input  wire spfs_pkg::spfs_line_in_t  line_i,
	output spfs_pkg::spfs_line_out_t      line_o,
	// Interrupt
	output logic                        irq_o
);
	import spfs_pkg::*;

	localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : byte_merge

	// Reserved select codes never trigger
	function automatic logic [AW:0] level_thr(input logic [2:0] sel);
		logic [AW:0] t;
		if (sel == SPFS_LVL_1) begin
			t = (AW+1)'(1);
		end else if (sel == SPFS_LVL_4) begin
			t = (AW+1)'(4);
		end else if (sel == SPFS_LVL_8) begin
			t = (AW+1)'(8);
		end else begin
			t = '1;
		end
		return t;
	endfunction : level_thr

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [31:0] ctrl_q;
	logic [7:0]  presc_q;
	logic [5:0]  mask_q;
	logic        ovr_q, tmo_q, und_q;
	logic        stg_q, stg_rd_q, pop_bus_q;
	logic [7:0]  adr_q;
	logic [31:0] wdat_q;
	logic [3:0]  sel_q;

	logic [4:0] size_m1;
	logic       slave_mode;
	logic [7:0] serial_clock_rate;
	logic [31:0] frame_mask;

	assign size_m1    = ctrl_q[SPFS_CTL_SIZE_LSB +: 5];
	assign slave_mode = ctrl_q[SPFS_CTL_SLAVE_BIT];
	assign serial_clock_rate        = ctrl_q[SPFS_CTL_SCR_LSB +: 8];
	assign frame_mask = 32'hFFFF_FFFF >> (5'd31 - size_m1);

	// FIFO state
	logic [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
	logic [AW:0]   tx_cnt_q, rx_cnt_q;
	logic          tx_push, tx_pop, rx_push, rx_pop;
	logic [31:0]   tx_rdata, rx_rdata, rx_wdata;
	logic          tx_empty, tx_full, rx_empty, rx_full;

	assign tx_empty = (tx_cnt_q == '0);
	assign tx_full  = (tx_cnt_q == DEPTH);
	assign rx_empty = (rx_cnt_q == '0);
	assign rx_full  = (rx_cnt_q == DEPTH);

	spfs_state_t st_q;
	logic [31:0] raw_ev, mis_ev;

	// ****************************************************************
	// Wishbone slave: request latched, answered one cycle later
	// ****************************************************************
	logic req;
	assign req = wb_cyc_i & wb_stb_i & ~stg_q & ~wb_ack_o;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			stg_q     <= 1'b0;
			stg_rd_q  <= 1'b0;
			pop_bus_q <= 1'b0;
			adr_q     <= 8'h00;
			wdat_q    <= 32'h0000_0000;
			sel_q     <= 4'h0;
		end else begin
			stg_q     <= req;
			stg_rd_q  <= req & ~wb_we_i;
			pop_bus_q <= rx_pop;
			if (req) begin
				adr_q  <= wb_adr_i;
				wdat_q <= wb_dat_i;
				sel_q  <= wb_sel_i;
			end
		end
	end

	assign rx_pop = req & ~wb_we_i & (wb_adr_i == SPFS_OFF_DATA) & ~rx_empty;
	// write pushes transmit FIFO; dropped when full
	assign tx_push = stg_q & ~stg_rd_q & (adr_q == SPFS_OFF_DATA)
		& (|sel_q) & ~tx_full;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= stg_q;
			wb_dat_o <= 32'h0000_0000;
			if (stg_rd_q) begin
				if (adr_q == SPFS_OFF_CTRL) begin
					wb_dat_o <= ctrl_q;
				end else if (adr_q == SPFS_OFF_DATA) begin
					wb_dat_o <= pop_bus_q ? rx_rdata : 32'h0000_0000;
				end else if (adr_q == SPFS_OFF_FLAGS) begin
					wb_dat_o[SPFS_FL_TXE]  <= tx_empty;
					wb_dat_o[SPFS_FL_TXR]  <= ~tx_full;
					wb_dat_o[SPFS_FL_RXD]  <= ~rx_empty;
					wb_dat_o[SPFS_FL_RXF]  <= rx_full;
					wb_dat_o[SPFS_FL_BUSY] <= (st_q != SPFS_IDLE) | ~tx_empty;
				end else if (adr_q == SPFS_OFF_PRESC) begin
					wb_dat_o[7:0] <= presc_q;
				end else if (adr_q == SPFS_OFF_MASK) begin
					wb_dat_o[5:0] <= mask_q;
				end else if (adr_q == SPFS_OFF_RAW) begin
					wb_dat_o <= raw_ev;
				end else if (adr_q == SPFS_OFF_MIS) begin
					wb_dat_o <= mis_ev;
				end
			end
		end
	end

	// Plain configuration registers
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q  <= SPFS_CTRL_RST;
			presc_q <= SPFS_PRESC_RST;
			mask_q  <= SPFS_MASK_RST;
		end else if (stg_q & ~stg_rd_q) begin
			if (adr_q == SPFS_OFF_CTRL) begin
				ctrl_q <= byte_merge(ctrl_q, wdat_q, sel_q) & SPFS_CTRL_WMSK;
			end else if (adr_q == SPFS_OFF_PRESC) begin
				presc_q <= sel_q[0] ? wdat_q[7:0] : presc_q;
			end else if (adr_q == SPFS_OFF_MASK) begin
				mask_q <= sel_q[0] ? wdat_q[5:0] : mask_q;
			end
		end
	end

	// ****************************************************************
	// FIFOs
	// ****************************************************************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_wp_q  <= '0;
			tx_rp_q  <= '0;
			tx_cnt_q <= '0;
		end else begin
			tx_wp_q  <= tx_wp_q + AW'(tx_push);
			tx_rp_q  <= tx_rp_q + AW'(tx_pop);
			tx_cnt_q <= tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_wp_q  <= '0;
			rx_rp_q  <= '0;
			rx_cnt_q <= '0;
		end else begin
			rx_wp_q  <= rx_wp_q + AW'(rx_push);
			rx_rp_q  <= rx_rp_q + AW'(rx_pop);
			rx_cnt_q <= rx_cnt_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
		end
	end

	spfs_mem #(.DW(32), .AW(AW)) u_tx_mem (
		.mclk    (mclk),
		.wr_en   (tx_push),
		.wr_addr (tx_wp_q),
		.wr_data (wdat_q),
		.rd_en   (tx_pop),
		.rd_addr (tx_rp_q),
		.rd_data (tx_rdata)
	);

	spfs_mem #(.DW(32), .AW(AW)) u_rx_mem (
		.mclk    (mclk),
		.wr_en   (rx_push),
		.wr_addr (rx_wp_q),
		.wr_data (rx_wdata),
		.rd_en   (rx_pop),
		.rd_addr (rx_rp_q),
		.rd_data (rx_rdata)
	);

	// ****************************************************************
	// Bit rate prescaler
	// ****************************************************************
	logic [6:0] pre_cnt_q, pre_lim;
	logic [7:0] scr_cnt_q;
	logic       half_tick_q, half_ph_q, bit_tick;

	// Odd or zero divisors are not legal; odd ones above 1 round to the even below, 0 and 1 act as 2
	assign pre_lim  = (presc_q[7:1] == 7'h00) ? 7'h00 : presc_q[7:1] - 7'h01;
	assign bit_tick = half_tick_q & half_ph_q;

	// half bit = divisor/2 times (rate+1) cycles
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pre_cnt_q   <= 7'h00;
			scr_cnt_q   <= 8'h00;
			half_tick_q <= 1'b0;
			half_ph_q   <= 1'b0;
		end else if (st_q == SPFS_LOAD) begin
			// Restart so the first edge trails select by a full half bit
			pre_cnt_q   <= 7'h00;
			scr_cnt_q   <= 8'h00;
			half_tick_q <= 1'b0;
			half_ph_q   <= 1'b0;
		end else begin
			half_tick_q <= 1'b0;
			if (half_tick_q) begin
				half_ph_q <= ~half_ph_q;
			end
			if (pre_cnt_q >= pre_lim) begin
				pre_cnt_q <= 7'h00;
				if (scr_cnt_q >= serial_clock_rate) begin
					scr_cnt_q   <= 8'h00;
					half_tick_q <= 1'b1;
				end else begin
					scr_cnt_q <= scr_cnt_q + 8'h01;
				end
			end else begin
				pre_cnt_q <= pre_cnt_q + 7'h01;
			end
		end
	end

	// ****************************************************************
	// Line input synchronisers
	// ****************************************************************
	logic [3:0] s1_q, s2_q, s3_q, lv_q, lv_prev_q;
	logic       sck_rise, sck_fall, cs_low;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			// Idle pin levels, so no false clock edge follows reset
			s1_q      <= 4'h1;
			s2_q      <= 4'h1;
			s3_q      <= 4'h1;
			lv_q      <= 4'h1;
			lv_prev_q <= 4'h1;
		end else begin
			s1_q      <= line_i;
			s2_q      <= s1_q;
			s3_q      <= s2_q;
			lv_prev_q <= lv_q;
			for (int i = 0; i < 4; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					lv_q[i] <= s3_q[i];
				end
			end
		end
	end

	// Bit order in vectors: 3 sclk, 2 mosi, 1 miso, 0 cs_n
	assign cs_low   = ~lv_q[0];

	// Agreed miso a cycle ahead of lv_q; a four-cycle half bit still
	// catches the answer to the previous falling edge
	logic miso_agree;
	assign miso_agree = (s2_q[1] == s3_q[1]) ? s3_q[1] : lv_q[1];
	assign sck_rise = lv_q[3] & ~lv_prev_q[3];
	assign sck_fall = ~lv_q[3] & lv_prev_q[3];

	// ****************************************************************
	// Shifter
	// ****************************************************************
	logic [31:0] txsh_q, rxsh_q, tx_next;
	logic [4:0]  bit_cnt_q;
	logic        rise_ev, fall_ev, din, frame_go, abort;
	logic        ovr_ev, und_ev, frame_end, done_q;

	// Slave lingers in DONE until select rises; store the frame only once
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (st_q == SPFS_DONE);
		end
	end
	assign frame_end = (st_q == SPFS_DONE) & ~done_q;

	// Master runs on prescaler ticks, slave on synchronised edges
	assign rise_ev  = slave_mode ? sck_rise : (half_tick_q & ~line_o.sclk);
	assign fall_ev  = slave_mode ? sck_fall : (half_tick_q & line_o.sclk);
	assign din      = slave_mode ? lv_q[2] : miso_agree;
	assign frame_go = slave_mode ? cs_low : ~tx_empty;
	assign abort    = slave_mode & ~cs_low;
	assign tx_next  = txsh_q << 1;
	assign tx_pop   = (st_q == SPFS_IDLE) & frame_go & ~tx_empty;
	assign und_ev   = (st_q == SPFS_IDLE) & slave_mode & cs_low & tx_empty;
	assign rx_push  = frame_end & ~rx_full;
	assign ovr_ev   = frame_end & rx_full;
	assign rx_wdata = rxsh_q & frame_mask;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q      <= SPFS_IDLE;
			txsh_q    <= 32'h0000_0000;
			rxsh_q    <= 32'h0000_0000;
			bit_cnt_q <= 5'h00;
		end else begin
			case (st_q)
				SPFS_IDLE: begin
					bit_cnt_q <= 5'h00;
					if (tx_pop) begin
						st_q <= SPFS_LOAD;
					end else if (und_ev) begin
						// Slave with nothing queued sends zeros
						txsh_q <= 32'h0000_0000;
						st_q   <= SPFS_SHIFT;
					end
				end
				SPFS_LOAD: begin
					txsh_q <= tx_rdata & frame_mask;
					st_q   <= SPFS_SHIFT;
				end
				SPFS_SHIFT: begin
					if (abort) begin
						st_q <= SPFS_IDLE;
					end else if (rise_ev) begin
						rxsh_q <= {rxsh_q[30:0], din};
					end else if (fall_ev) begin
						txsh_q    <= tx_next;
						bit_cnt_q <= bit_cnt_q + 5'h01;
						if (bit_cnt_q == size_m1) begin
							st_q <= SPFS_DONE;
						end
					end
				end
				SPFS_DONE: begin
					// Slave waits for select release before next frame
					if (~abort | ~slave_mode) begin
						st_q <= slave_mode ? SPFS_DONE : SPFS_IDLE;
					end
					if (abort) begin
						st_q <= SPFS_IDLE;
					end
				end
				default: begin
					st_q <= SPFS_IDLE;
				end
			endcase
		end
	end

	// Line outputs, all from flops
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			line_o <= '{sclk: 1'b0, sclk_oe: 1'b0, mosi: 1'b0, mosi_oe: 1'b0,
				miso: 1'b0, miso_oe: 1'b0, cs_n: 1'b1, cs_n_oe: 1'b0};
		end else begin
			line_o.sclk_oe <= ~slave_mode;
			line_o.mosi_oe <= ~slave_mode;
			line_o.cs_n_oe <= ~slave_mode;
			line_o.miso_oe <= slave_mode & cs_low;
			line_o.cs_n    <= slave_mode | (st_q == SPFS_IDLE)
				| (st_q == SPFS_DONE);
			if (st_q != SPFS_SHIFT) begin
				line_o.sclk <= 1'b0;
			end else if (~slave_mode & half_tick_q) begin
				line_o.sclk <= ~line_o.sclk;
			end
			if (st_q == SPFS_LOAD) begin
				line_o.mosi <= tx_rdata[size_m1];
				line_o.miso <= tx_rdata[size_m1];
			end else if (st_q == SPFS_IDLE) begin
				line_o.mosi <= 1'b0;
				line_o.miso <= 1'b0;
			end else if (st_q == SPFS_SHIFT & fall_ev) begin
				line_o.mosi <= tx_next[size_m1];
				line_o.miso <= tx_next[size_m1];
			end
		end
	end

	// ****************************************************************
	// Events and interrupt
	// ****************************************************************
	logic [5:0] tmo_cnt_q;
	logic [AW:0] rx_thr, tx_thr;

	assign rx_thr = level_thr(ctrl_q[SPFS_CTL_RXSEL_LSB +: 3]);
	assign tx_thr = level_thr(ctrl_q[SPFS_CTL_TXSEL_LSB +: 3]);

	// count bit periods, restart on any receive FIFO access and while it is empty
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tmo_cnt_q <= 6'h00;
		end else if (rx_empty | rx_push | rx_pop) begin
			tmo_cnt_q <= 6'h00;
		end else if (bit_tick & (tmo_cnt_q < SPFS_TMO_BITS)) begin
			tmo_cnt_q <= tmo_cnt_q + 6'h01;
		end
	end

	// Sticky events; a new event wins over a clear in the same cycle
	logic clr_wr;
	assign clr_wr = stg_q & ~stg_rd_q & (adr_q == SPFS_OFF_CLR) & sel_q[0];

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ovr_q <= 1'b0;
			tmo_q <= 1'b0;
			und_q <= 1'b0;
		end else begin
			if (clr_wr & wdat_q[0]) begin
				ovr_q <= 1'b0;
			end
			if (clr_wr & wdat_q[1]) begin
				tmo_q <= 1'b0;
			end
			if (clr_wr & wdat_q[2]) begin
				und_q <= 1'b0;
			end
			if (ovr_ev) begin
				ovr_q <= 1'b1;
			end
			if (bit_tick & (tmo_cnt_q == SPFS_TMO_BITS - 6'h01)
					& ~rx_empty & ~rx_push & ~rx_pop) begin
				tmo_q <= 1'b1;
			end
			if (und_ev) begin
				und_q <= 1'b1;
			end
		end
	end

	always_comb begin
		raw_ev = 32'h0000_0000;
		raw_ev[SPFS_EV_OVR] = ovr_q;
		raw_ev[SPFS_EV_TMO] = tmo_q;
		raw_ev[SPFS_EV_RXL] = (rx_cnt_q >= rx_thr);
		raw_ev[SPFS_EV_TXL] = (tx_cnt_q >= tx_thr);
		raw_ev[SPFS_EV_UND] = und_q;
		raw_ev[SPFS_EV_TXE] = tx_empty;
		mis_ev = raw_ev & {26'h0, mask_q};
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |mis_ev;
		end
	end
endmodule : spfs_top

// ---- testbench/spfs_asserts.sv ----
// Concurrent checks on the serial port block's bus, interrupt and line pins
`timescale 1ns/1ps
module spfs_asserts
	import spfs_pkg::*;
#(
	parameter int AW = 3
) (
	// Clock and reset
	input wire logic                    mclk,
	input wire logic                    sys_rst,
	// Wishbone
	input wire logic                    wb_cyc_i,
	input wire logic                    wb_stb_i,
	input wire logic                    wb_we_i,
	input wire logic [7:0]              wb_adr_i,
	input wire logic [3:0]              wb_sel_i,
	input wire logic [31:0]             wb_dat_i,
	input wire logic [31:0]             wb_dat_o,
	input wire logic                    wb_ack_o,
	// Line and interrupt
	input wire spfs_pkg::spfs_line_in_t  line_i,
	input wire spfs_pkg::spfs_line_out_t line_o,
	input wire logic                    irq_o
);
	import spfs_pkg::*;
	logic [5:0] mask_sh_q;
	logic       rd_ack;
	assign rd_ack = wb_ack_o && !wb_we_i;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	// Shadow of the enable mask, taken when the write completes
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_sh_q <= 6'h00;
		end else if (wb_ack_o && wb_we_i && wb_adr_i == SPFS_OFF_MASK
				&& wb_sel_i[0]) begin
			mask_sh_q <= wb_dat_i[5:0];
		end
	end
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_ack_delay: assert property (
		$rose(wb_cyc_i && wb_stb_i) |=> !wb_ack_o ##1 wb_ack_o)
		else $error("ack not two cycles after request");
	chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chk_flag_bits: assert property (
		rd_ack && wb_adr_i == SPFS_OFF_FLAGS |-> wb_dat_o[31:5] == 27'h0
		&& (!wb_dat_o[0] || wb_dat_o[1]) && (wb_dat_o[0] || wb_dat_o[4])
		&& (!wb_dat_o[3] || wb_dat_o[2]))
		else $error("flag word inconsistent");
	chk_raw_width: assert property (
		rd_ack && wb_adr_i == SPFS_OFF_RAW |-> wb_dat_o[31:6] == 26'h0)
		else $error("raw word has upper bits");
	chk_masked_sub: assert property (
		rd_ack && wb_adr_i == SPFS_OFF_MIS |-> wb_dat_o[31:6] == 26'h0
		&& (wb_dat_o[5:0] & ~mask_sh_q) == 6'h00)
		else $error("masked word outside mask");
	chk_mask_read: assert property (
		rd_ack && wb_adr_i == SPFS_OFF_MASK |-> wb_dat_o == {26'h0, mask_sh_q})
		else $error("mask readback wrong");
	chk_irq_off: assert property (
		wb_ack_o && wb_we_i && wb_adr_i == SPFS_OFF_MASK && wb_sel_i[0]
		&& wb_dat_i[5:0] == 6'h00 |=> !irq_o [*3])
		else $error("irq with all sources masked");
	chk_sclk_idle: assert property (line_o.cs_n |-> !line_o.sclk)
		else $error("clock moves outside frame");
	chk_cs_gap: assert property ($rose(line_o.cs_n) |=> line_o.cs_n)
		else $error("select gap under two cycles");
	chk_presc_width: assert property (
		rd_ack && wb_adr_i == SPFS_OFF_PRESC |-> wb_dat_o[31:8] == 24'h0)
		else $error("prescaler upper bits set");
	chk_drive_roles: assert property (
		!line_o.cs_n |-> line_o.sclk_oe && line_o.mosi_oe
		&& line_o.cs_n_oe && !line_o.miso_oe)
		else $error("pin drive wrong during frame");
endmodule : spfs_asserts

bind spfs_top spfs_asserts #(.AW(AW)) u_chk (
	.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .line_i(line_i), .line_o(line_o), .irq_o(irq_o)
);

// ---- testbench/spfs_peer.sv ----
// Serial slave stand-in on the block's line side, mode 0
`timescale 1ns/1ps
module spfs_peer
	import spfs_pkg::*;
#(
	parameter logic [7:0] REPLY = 8'h3C
) (
	// Pins
	input  wire spfs_pkg::spfs_line_out_t pins_o,
	output spfs_pkg::spfs_line_in_t       pins_i,
	// Last frame taken in
	output logic [7:0]                    got_q
);
	logic [7:0] sh_q;
	logic       miso_q = 1'b0;
	logic       sclk_w;
	logic       cs_n_w;
	// Select pulled up, clock pulled down when undriven
	assign cs_n_w = pins_o.cs_n_oe ? pins_o.cs_n : 1'b1;
	assign sclk_w = pins_o.sclk_oe ? pins_o.sclk : 1'b0;
	assign pins_i = {sclk_w, pins_o.mosi, miso_q, cs_n_w};
	always @(negedge cs_n_w) begin
		sh_q = REPLY;
		miso_q = REPLY[7];
	end
	always @(posedge sclk_w) begin
		if (!cs_n_w) begin
			got_q = {got_q[6:0], pins_o.mosi};
		end
	end
	always @(negedge sclk_w) begin
		if (!cs_n_w) begin
			sh_q = {sh_q[6:0], 1'b0};
			miso_q = sh_q[7];
		end
	end
	// Released line no longer shows its last bit
	always @(posedge cs_n_w) begin
		miso_q = ~miso_q;
	end
endmodule : spfs_peer

// ---- testbench/tb_spfs_top.sv ----
// Self-checking bench for the serial port register block
`timescale 1ns/1ps
module tb_spfs_top;
	import spfs_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic           mclk = 1'b0;
	logic           sys_rst = 1'b1;
	logic           wb_cyc_i = 1'b0;
	logic           wb_stb_i = 1'b0;
	logic           wb_we_i = 1'b0;
	logic [7:0]     wb_adr_i = 8'h00;
	logic [3:0]     wb_sel_i = 4'hF;
	logic [31:0]    wb_dat_i = 32'h0;
	logic [31:0]    wb_dat_o;
	logic           wb_ack_o;
	logic           irq_o;
	spfs_line_in_t  line_i;
	spfs_line_out_t line_o;
	int             err_total = 0;
	int             check_count = 0;

	always #2.5 mclk = ~mclk;

	spfs_top dut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .line_i(line_i), .line_o(line_o),
		.irq_o(irq_o));
	spfs_peer u_peer (.pins_o(line_o), .pins_i(line_i), .got_q());

	// ****
	// Shared tasks
	// ****
	task automatic wrap_up();
		$display("mismatches %0d, checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic bail();
		err_total++;
		$display("[FAIL] %0t wait ran out", $time);
		wrap_up();
	endtask : bail

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t saw %h want %h", $time, seen, exp);
		end
	endtask : check

	// Classic cycle: hold until ack is sampled, then drop for a cycle
	task automatic bus(input logic we, input logic [7:0] adr,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 50) begin
			bail();
		end
	endtask : bus

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, adr, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] m,
			input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, adr, 32'h0, q);
		check(q & m, exp);
	endtask : rd_chk

	task automatic wait_idle();
		logic [31:0] q;
		int          n;
		n = 0;
		do begin
			bus(1'b0, SPFS_OFF_FLAGS, 32'h0, q);
			n++;
		end while (q[SPFS_FL_BUSY] !== 1'b0 && n < 400);
		if (n >= 400) begin
			bail();
		end
	endtask : wait_idle

	task automatic wait_sclk(input logic lvl, output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (line_o.sclk !== lvl && n < 300);
		if (n >= 300) begin
			bail();
		end
	endtask : wait_sclk

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		rd_chk(SPFS_OFF_FLAGS, ALL, 32'h3);
		rd_chk(SPFS_OFF_RAW, ALL, 32'h20);
		rd_chk(SPFS_OFF_MASK, ALL, 32'h0);
		rd_chk(SPFS_OFF_PRESC, ALL, 32'h0);
		wr(8'h40, 32'h5A);
		rd_chk(8'h40, ALL, 32'h0);
		check({31'h0, irq_o}, 32'h0);
	endtask : t_reset

	task automatic t_mask();
		for (int i = 0; i < SPFS_NUM_EV; i++) begin
			wr(SPFS_OFF_MASK, 32'h1 << i);
			rd_chk(SPFS_OFF_MIS, ALL, (i == 5) ? 32'h20 : 32'h0);
			check({31'h0, irq_o}, {31'h0, i == 5});
		end
		wr(SPFS_OFF_MASK, 32'h0);
		// Interrupt output follows the mask write one edge later
		@(posedge mclk);
		check({31'h0, irq_o}, 32'h0);
	endtask : t_mask

	task automatic t_frame();
		wr(SPFS_OFF_PRESC, 32'h8);
		wr(SPFS_OFF_DATA, 32'h1A5);
		rd_chk(SPFS_OFF_FLAGS, 32'h10, 32'h10);
		wait_idle();
		check({24'h0, u_peer.got_q}, 32'hA5);
		rd_chk(SPFS_OFF_FLAGS, ALL, 32'h7);
		rd_chk(SPFS_OFF_DATA, ALL, 32'h3C);
		rd_chk(SPFS_OFF_FLAGS, ALL, 32'h3);
	endtask : t_frame

	task automatic t_rate();
		int a;
		int b;
		wr(SPFS_OFF_CTRL, 32'h107);
		wr(SPFS_OFF_DATA, 32'h55);
		wait_sclk(1'b1, a);
		wait_sclk(1'b0, a);
		wait_sclk(1'b1, b);
		check(32'(a + b), 32'h10);
		wait_idle();
		check({24'h0, u_peer.got_q}, 32'h55);
		rd_chk(SPFS_OFF_DATA, ALL, 32'h3C);
	endtask : t_rate

	task automatic t_overrun();
		// Receive level select four
		wr(SPFS_OFF_CTRL, 32'h10007);
		for (int i = 0; i < 9; i++) begin
			wr(SPFS_OFF_DATA, 32'h10 + i);
		end
		wait_idle();
		rd_chk(SPFS_OFF_FLAGS, ALL, 32'hF);
		rd_chk(SPFS_OFF_RAW, 32'h5, 32'h5);
		// Over 32 bit periods of 8 cycles
		repeat (320) @(posedge mclk);
		rd_chk(SPFS_OFF_RAW, 32'h2, 32'h2);
		wr(SPFS_OFF_CLR, 32'h0);
		rd_chk(SPFS_OFF_RAW, 32'h3, 32'h3);
		rd_chk(SPFS_OFF_DATA, ALL, 32'h3C);
		wr(SPFS_OFF_CLR, 32'h3);
		rd_chk(SPFS_OFF_RAW, 32'h3, 32'h0);
		for (int i = 0; i < 7; i++) begin
			rd_chk(SPFS_OFF_DATA, ALL, 32'h3C);
			if (i == 3) begin
				rd_chk(SPFS_OFF_RAW, 32'h4, 32'h0);
			end
		end
		rd_chk(SPFS_OFF_FLAGS, ALL, 32'h3);
		rd_chk(SPFS_OFF_DATA, ALL, 32'h0);
	endtask : t_overrun

	initial begin
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_mask();
		t_frame();
		t_rate();
		t_overrun();
		wrap_up();
	end
endmodule : tb_spfs_top
